// ### verilog/demod_cfg.svh
// constants of the demodulator serial configuration bank
`ifndef DEMOD_CFG_SVH
`define DEMOD_CFG_SVH
`define WORD_W 32
`define ADDR_W 5
`define REGNUM_LSB 0
`define REGNUM_W 3
`define BANK_LSB 3
`define BANK_W 2
`define CFG_BANK 2'h1
`define REG_READOUT 3'h0
`define REG_SETUP 3'h1
`define REG_CAL 3'h2
`define REG_LOAD 3'h3
`define REG_BIAS 3'h5
`define READ_CMD 5'h08
`define READ_SEL_LSB 28
`define READOUT_ADDR 5'h08
// version identifier; the value is arbitrary
`define VERSION_ID 2'h2
`define RST_SETUP 32'h0100FC89
`define RST_CAL 32'h71E0200A
`define RST_LOAD 32'h4000000B
`define RST_BIAS 32'h0000AAAD
`define BIAS_MASK 32'h0001FFFF
`define RST_CODE 8'h80
`define GAIN_MAX 5'h18
`define CAL_START_BIT 5
`define READ_BITS 6'h20
`endif

// ### verilog/demod_pkg.sv
// types of the demodulator serial configuration bank
`default_nettype none

package demod_pkg;
    typedef struct packed {
        logic output_attenuator_enable;
        logic unused30;
        logic osc_test;
        logic gain_step_double;
        logic external_gain_step_enable;
        logic detector_capacitor_bypass;
        logic detector_resistor_bypass;
        logic [7:0] lowpass_corner_code;
        logic [4:0] amplifier_gain_code;
        logic unused11;
        logic offset_cal_logic_sleep;
        logic unused9;
        logic filter_sleep;
        logic test_buffer_sleep;
        logic unused6;
        logic mixer_sleep;
        logic [4:0] addr;
    } setup_t;
    typedef struct packed {
        logic [2:0] osc_trim;
        logic cal_clock_internal;
        logic [2:0] clk_div_code;
        logic auto_codes_select;
        logic correction_range_msb;
        logic correction_range_lsb;
        logic [7:0] q_manual_correction_code;
        logic [7:0] i_manual_correction_code;
        logic cal_start;
        logic [4:0] addr;
    } cal_ctrl_t;
    typedef struct packed {
        logic [1:0] peaking_ctrl;
        logic filter_bypass;
        logic [5:0] q_mixer_load_side_b;
        logic [5:0] q_mixer_load_side_a;
        logic [5:0] i_mixer_load_side_b;
        logic [5:0] i_mixer_load_side_a;
        logic [4:0] addr;
    } load_t;
    typedef struct packed {
        logic [14:0] unused;
        logic [1:0] output_buffer_bias;
        logic [1:0] filter_bias;
        logic [1:0] mixer_buffer_bias;
        logic [1:0] oscillator_buffer_bias;
        logic [1:0] mixer_switch_common_mode_bias;
        logic [1:0] mixer_transconductance_bias;
        logic [4:0] addr;
    } bias_t;
    typedef struct packed {
        logic [7:0] i_calibrated_correction_code;
        logic [7:0] q_calibrated_correction_code;
        logic [8:0] unused;
        logic [1:0] version_field;
        logic [4:0] addr;
    } readout_t;
    typedef struct packed {
        logic [7:0] i_code;
        logic [7:0] q_code;
    } cal_result_t;
endpackage

`default_nettype wire

// ### verilog/demod_serial_config_bank.sv
// serial configuration and readback register bank of the demodulator
//
// Behaviour
// - host shifts 32-bit words lsb first, sampled on serial clock rise.
// - strobe rise copies the shift register into the addressed register.
// - after readback strobe, one idle clock, then 32 bits lsb first.
// - readback word is 0,0,0,1,0 low bits plus register number above.
// - register 0 returns address, version, q code and i code.
// - register 1 power-down bits for mixer, buffer, filter, cal logic.
// - register 1 bits 12-16 gain code, reset 15, legal 0 to 24.
// - register 1 bits 17-24 low-pass corner code, reset 128.
// - register 1 bits 25-26 bypass detector filter resistor, capacitor.
// - register 1 bit 27 enables fast gain, bit 28 doubles step.
// - register 1 bit 29 puts the oscillator on the return output.
// - register 1 bit 31 enables the output attenuator, reset 0.
// - register 2 bit 5 starts calibration, cleared by device when done.
// - register 2 bits 6-13 manual i correction code, reset 128.
// - register 2 bits 14-21 manual q correction code, reset 128.
// - register 2 bits 22-23 correction range, reset 11.
// - register 2 bit 24 selects automatic codes, reset 1.
// - register 2 bits 25-27 choose calibration clock divider ratio.
// - register 2 bit 28 selects internal oscillator, reset 1.
// - register 2 bits 29-31 trim oscillator frequency, reset 011.
// - register 3 holds four six-bit mixer load fields, reset 0.
// - register 3 bit 29 filter bypass, bits 30-31 peaking control.
// - register 5 bits 5-16 six two-bit bias trims, reset 1.
`timescale 1ns/1ns
`default_nettype none
`include "demod_cfg.svh"

module demod_serial_config_bank
    import demod_pkg::*;
(
    input wire logic clk_i,                // system clock, 50 MHz
    input wire logic rst_i,                // synchronous reset
    input wire logic ser_clk_i,            // serial clock pin
    input wire logic ser_data_i,           // serial data pin
    input wire logic ser_strobe_i,         // load strobe pin
    input wire logic osc_i,                // calibration oscillator
    input wire logic cal_done_i,           // calibration finished pulse
    input wire cal_result_t cal_result_i,  // calibrated codes
    output logic readback_o,               // serial return output
    output setup_t setup_o,                // general device setup
    output cal_ctrl_t cal_ctrl_o,          // offset calibration control
    output load_t load_o,                  // mixer load and filter
    output bias_t bias_o,                  // bias trims
    output logic [14:0] cal_div_ratio_o    // decoded divider ratio
);

    // ************************************************************
    // decoding helpers
    // ************************************************************

    // true when a word addresses register num in the bank
    function automatic logic hits(input logic [31:0] w,
                                  input logic [2:0] num);
        hits = (w[`BANK_LSB +: `BANK_W] == `CFG_BANK) &&
               (w[`REGNUM_LSB +: `REGNUM_W] == num);
    endfunction

    // divider ratio from its three-bit code
    function automatic logic [14:0] div_ratio(input logic [2:0] c);
        case (c)
            3'h0: div_ratio = 15'h0001;
            3'h1: div_ratio = 15'h0008;
            3'h2: div_ratio = 15'h0010;
            3'h3: div_ratio = 15'h0080;
            3'h4: div_ratio = 15'h0100;
            3'h5: div_ratio = 15'h0400;
            3'h6: div_ratio = 15'h0800;
            default: div_ratio = 15'h412C;
        endcase
    endfunction

    // ************************************************************
    // pin synchronisers
    // ************************************************************

    logic [3:0] pin_raw;
    logic [3:0] sync1_q;
    logic [3:0] sync2_q;
    logic [3:0] sync3_q;
    logic [3:0] pin_q;
    logic [3:0] pin_prev_q;

    assign pin_raw = {osc_i, ser_strobe_i, ser_data_i, ser_clk_i};

    // three stages; a level counts once stages two and three agree
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_sync
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    sync1_q[g] <= 1'b0;
                    sync2_q[g] <= 1'b0;
                    sync3_q[g] <= 1'b0;
                    pin_q[g] <= 1'b0;
                    pin_prev_q[g] <= 1'b0;
                end else begin
                    sync1_q[g] <= pin_raw[g];
                    sync2_q[g] <= sync1_q[g];
                    sync3_q[g] <= sync2_q[g];
                    if (sync2_q[g] == sync3_q[g]) begin
                        pin_q[g] <= sync3_q[g];
                    end
                    pin_prev_q[g] <= pin_q[g];
                end
            end
        end
    endgenerate

    logic sclk_rise;
    logic strobe_rise;
    logic data_lvl;
    logic osc_lvl;

    assign sclk_rise = pin_q[0] & ~pin_prev_q[0];
    assign data_lvl = pin_q[1];
    assign strobe_rise = pin_q[2] & ~pin_prev_q[2];
    assign osc_lvl = pin_q[3];

    // ************************************************************
    // input shift register
    // ************************************************************

    logic [31:0] shift_q;

    // lsb arrives first and ends in bit 0 after 32 clocks
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            shift_q <= '0;
        end else if (sclk_rise) begin
            shift_q <= {data_lvl, shift_q[31:1]};
        end
    end

    // ************************************************************
    // configuration registers
    // ************************************************************

    logic [31:0] setup_q;
    logic [31:0] cal_q;
    logic [31:0] load_q;
    logic [31:0] bias_q;
    logic [31:0] setup_d;
    logic wr_setup;
    logic wr_cal;
    logic wr_load;
    logic wr_bias;

    // write strobes; register 4 and other banks are ignored
    assign wr_setup = strobe_rise && hits(shift_q, `REG_SETUP);
    assign wr_cal = strobe_rise && hits(shift_q, `REG_CAL);
    assign wr_load = strobe_rise && hits(shift_q, `REG_LOAD);
    assign wr_bias = strobe_rise && hits(shift_q, `REG_BIAS);

    // gain above the legal top is held at the top
    always_comb begin
        setup_d = shift_q;
        if (shift_q[16:12] > `GAIN_MAX) begin
            setup_d[16:12] = `GAIN_MAX;
        end
    end

    // register 1: power-downs, gain, filter, fast gain, test, attenuator
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            setup_q <= `RST_SETUP;
        end else if (wr_setup) begin
            setup_q <= setup_d;
        end
    end

    // register 2; a start written with a done pulse still starts
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cal_q <= `RST_CAL;
        end else if (wr_cal) begin
            cal_q <= shift_q;
        end else if (cal_done_i) begin
            cal_q[`CAL_START_BIT] <= 1'b0;
        end
    end

    // register 3: mixer loads and filter bypass
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            load_q <= `RST_LOAD;
        end else if (wr_load) begin
            load_q <= shift_q;
        end
    end

    // register 5: bias trims, unused upper bits kept at zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bias_q <= `RST_BIAS;
        end else if (wr_bias) begin
            bias_q <= shift_q & `BIAS_MASK;
        end
    end

    // ************************************************************
    // calibration results and divider
    // ************************************************************

    logic [7:0] i_code_q;
    logic [7:0] q_code_q;
    logic [14:0] div_q;

    // codes start at half scale and hold until the next calibration
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            i_code_q <= `RST_CODE;
            q_code_q <= `RST_CODE;
        end else if (cal_done_i) begin
            i_code_q <= cal_result_i.i_code;
            q_code_q <= cal_result_i.q_code;
        end
    end

    // decoded ratio of the calibration clock divider
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            div_q <= 15'h0001;
        end else begin
            div_q <= div_ratio(cal_q[27:25]);
        end
    end

    // ************************************************************
    // readback
    // ************************************************************

    readout_t readout;
    logic [31:0] read_word;
    logic [2:0] read_sel;
    logic read_cmd;

    assign readout.i_calibrated_correction_code = i_code_q;
    assign readout.q_calibrated_correction_code = q_code_q;
    assign readout.unused = '0;
    assign readout.version_field = `VERSION_ID; // arbitrary value
    assign readout.addr = `READOUT_ADDR;

    // readback request: fixed low bits, register number up top
    assign read_cmd = strobe_rise &&
                      (shift_q[`ADDR_W-1:0] == `READ_CMD);
    assign read_sel = shift_q[`READ_SEL_LSB +: `REGNUM_W];

    // selected register word
    always_comb begin
        read_word = '0;
        if (read_sel == `REG_READOUT) begin
            read_word = readout;
        end else if (read_sel == `REG_SETUP) begin
            read_word = setup_q;
        end else if (read_sel == `REG_CAL) begin
            read_word = cal_q;
        end else if (read_sel == `REG_LOAD) begin
            read_word = load_q;
        end else if (read_sel == `REG_BIAS) begin
            read_word = bias_q;
        end
    end

    typedef enum logic [1:0] {RB_IDLE, RB_SKIP, RB_SEND} rb_state_t;
    rb_state_t rb_q;
    logic [31:0] rb_shift_q;
    logic [5:0] rb_count_q;
    logic rb_bit_q;

    // one idle serial clock, then 32 bits on rising edges
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rb_q <= RB_IDLE;
            rb_shift_q <= '0;
            rb_count_q <= '0;
            rb_bit_q <= 1'b0;
        end else if (read_cmd) begin
            rb_q <= RB_SKIP;
            rb_shift_q <= read_word;
            rb_count_q <= '0;
        end else if (sclk_rise) begin
            case (rb_q)
                RB_SKIP: begin
                    rb_q <= RB_SEND;
                end
                RB_SEND: begin
                    rb_bit_q <= rb_shift_q[0];
                    rb_shift_q <= {1'b0, rb_shift_q[31:1]};
                    rb_count_q <= rb_count_q + 6'h01;
                    if (rb_count_q == `READ_BITS - 6'h01) begin
                        rb_q <= RB_IDLE;
                    end
                end
                default: begin
                    rb_q <= RB_IDLE;
                end
            endcase
        end
    end

    // return pin carries the oscillator in test mode
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            readback_o <= 1'b0;
        end else if (setup_q[29]) begin
            readback_o <= osc_lvl;
        end else begin
            readback_o <= rb_bit_q;
        end
    end

    // ************************************************************
    // control outputs
    // ************************************************************

    assign setup_o = setup_q;
    assign cal_ctrl_o = cal_q;
    assign load_o = load_q;
    assign bias_o = bias_q;
    assign cal_div_ratio_o = div_q;

endmodule

`default_nettype wire

// ### sim/host_model.sv
// host controller model driving the three-wire serial port
`timescale 1ns/1ns
`default_nettype none

module host_model (
    input wire logic clk_i, // system clock
    input wire logic readback_i, // serial return
    output logic ser_clk_o, // serial clock
    output logic ser_data_o, // serial data
    output logic ser_strobe_o // load strobe
);
    // serial clock and strobe idle low between frames
    initial begin
        ser_clk_o = 1'b0;
        ser_data_o = 1'b0;
        ser_strobe_o = 1'b0;
    end

    task automatic wait_n(input int n);
        repeat (n) @(negedge clk_i);
    endtask

    // one clock pulse carrying d; return sampled just before the fall
    task automatic pulse(input logic d, output logic r);
        ser_data_o = d;
        wait_n(3);
        ser_clk_o = 1'b1;
        wait_n(8);
        r = readback_i;
        ser_clk_o = 1'b0;
        wait_n(4);
    endtask

    // shift a word lsb first, then strobe it in
    task automatic send(input logic [31:0] w);
        logic r;
        for (int i = 0; i < 32; i++) pulse(w[i], r);
        ser_data_o = ~w[31]; // line no longer holds the last bit
        wait_n(4);
        ser_strobe_o = 1'b1;
        wait_n(6);
        ser_strobe_o = 1'b0;
        wait_n(6);
    endtask

    // readback command, one idle clock, then 32 data clocks
    task automatic read(input logic [2:0] n, output logic [31:0] v);
        logic r;
        send({1'b0, n, 28'h0000008});
        pulse(1'b0, r);
        for (int i = 0; i < 32; i++) pulse(1'b0, v[i]);
    endtask
endmodule
`default_nettype wire

// ### sim/demod_bank_assertions.sv
// port checker of the serial configuration bank
`timescale 1ns/1ns
`default_nettype none

module demod_bank_checker
    import demod_pkg::*;
(
    input wire logic clk_i, // clock
    input wire logic rst_i, // reset
    input wire logic ser_clk_i, // serial clock
    input wire logic ser_data_i, // serial data
    input wire logic ser_strobe_i, // strobe
    input wire logic osc_i, // oscillator
    input wire logic cal_done_i, // calibration done
    input wire cal_result_t cal_result_i, // calibrated codes
    input wire logic readback_o, // serial return
    input wire setup_t setup_o, // register 1
    input wire cal_ctrl_t cal_ctrl_o, // register 2
    input wire load_t load_o, // register 3
    input wire bias_t bias_o, // register 5
    input wire logic [14:0] cal_div_ratio_o // divider ratio
);
    localparam logic [14:0] RATIO [8] = '{15'h0001, 15'h0008, 15'h0010,
        15'h0080, 15'h0100, 15'h0400, 15'h0800, 15'h412C};
    logic sclk_q, strb_q;
    logic [7:0] sclk_age_q, strb_age_q;

    // cycles since the serial clock and the strobe last rose
    always_ff @(posedge clk_i) begin
        sclk_q <= ser_clk_i;
        strb_q <= ser_strobe_i;
        if (ser_clk_i && !sclk_q) sclk_age_q <= 8'h00;
        else if (rst_i || sclk_age_q == 8'hFF) sclk_age_q <= 8'hFF;
        else sclk_age_q <= sclk_age_q + 8'h01;
        if (ser_strobe_i && !strb_q) strb_age_q <= 8'h00;
        else if (rst_i || strb_age_q == 8'hFF) strb_age_q <= 8'hFF;
        else strb_age_q <= strb_age_q + 8'h01;
    end

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    reset_values_a: assert property (
        $fell(rst_i) |-> setup_o == 32'h0100FC89 && cal_ctrl_o ==
        32'h71E0200A && load_o == 32'h4000000B && bias_o == 32'h0000AAAD)
        else $error("register values wrong after reset");
    gain_clamp_a: assert property (
        setup_o.amplifier_gain_code <= 5'h18)
        else $error("gain code above its maximum");
    bias_unused_a: assert property (bias_o.unused == 15'h0000)
        else $error("unused bias bits not zero");
    write_on_strobe_a: assert property (
        $changed(setup_o) || $changed(load_o) || $changed(bias_o) ||
        ($changed(cal_ctrl_o) && !$past(cal_done_i)) |-> strb_age_q <= 8'd10)
        else $error("register changed without a strobe");
    start_set_a: assert property (
        $rose(cal_ctrl_o.cal_start) |-> strb_age_q <= 8'd10)
        else $error("calibration start set without a write");
    start_clear_a: assert property (
        cal_done_i && strb_age_q > 8'd6 |=> !cal_ctrl_o.cal_start)
        else $error("calibration start not cleared when done");
    ratio_decode_a: assert property (
        cal_div_ratio_o == RATIO[$past(cal_ctrl_o.clk_div_code)])
        else $error("divider ratio does not match its code");
    osc_follow_a: assert property (
        (setup_o.osc_test && $stable(osc_i)) [*8] |-> readback_o == osc_i)
        else $error("return output does not follow the oscillator");
    readback_quiet_a: assert property (
        $changed(readback_o) && !setup_o.osc_test && !$past(setup_o.osc_test)
        |-> sclk_age_q <= 8'd10 || strb_age_q <= 8'd10)
        else $error("return output moved without a serial clock");
    addr_fields_a: assert property (
        setup_o.addr == 5'h09 && cal_ctrl_o.addr == 5'h0A &&
        load_o.addr == 5'h0B && bias_o.addr == 5'h0D)
        else $error("stored address field wrong");

    start_done_c: cover property ($fell(cal_ctrl_o.cal_start));
    osc_seen_c: cover property (setup_o.osc_test && $changed(readback_o));
    ratio_move_c: cover property ($changed(cal_div_ratio_o));
endmodule

bind demod_serial_config_bank demod_bank_checker i_demod_bank_checker (
    .clk_i(clk_i), .rst_i(rst_i), .ser_clk_i(ser_clk_i),
    .ser_data_i(ser_data_i), .ser_strobe_i(ser_strobe_i), .osc_i(osc_i),
    .cal_done_i(cal_done_i), .cal_result_i(cal_result_i),
    .readback_o(readback_o), .setup_o(setup_o), .cal_ctrl_o(cal_ctrl_o),
    .load_o(load_o), .bias_o(bias_o), .cal_div_ratio_o(cal_div_ratio_o)
);
`default_nettype wire

// ### sim/test_demod_serial_config_bank.sv
// self-checking bench of the serial configuration bank
`timescale 1ns/1ns
`default_nettype none
`include "demod_cfg.svh"

module test_demod_serial_config_bank
    import demod_pkg::*;
;
    logic clk_i, rst_i, ser_clk, ser_data, ser_strobe, osc_i, cal_done_i;
    logic readback_o;
    logic [14:0] cal_div_ratio_o;
    cal_result_t cal_result_i;
    setup_t setup_o;
    cal_ctrl_t cal_ctrl_o;
    load_t load_o;
    bias_t bias_o;
    int n_fail = 0;
    int checked = 0;
    int cycles = 0;
    // raw words, register each lands in (0: refused), value then held
    logic [31:0] tw [8] = '{32'h9BFF9129, 32'h9BFF8129, 32'hAC56B0CA,
        32'hA5A5A5AB, 32'hFFFFFFED, 32'h0000C9CD, 32'h5A5A5A0C, 32'h5A5A5A51};
    logic [2:0] treg [8] = '{3'h1, 3'h1, 3'h2, 3'h3, 3'h5, 3'h5, 3'h0, 3'h0};
    logic [31:0] texp [8] = '{32'h9BFF8129, 32'h9BFF8129, 32'hAC56B0CA,
        32'hA5A5A5AB, 32'h0001FFED, 32'h0000C9CD, 32'h0, 32'h0};
    logic [31:0] sh [8] = '{32'h0, 32'h0100FC89, 32'h71E0200A,
        32'h4000000B, 32'h0, 32'h0000AAAD, 32'h0, 32'h0};
    logic [14:0] rt [8] = '{15'h0001, 15'h0008, 15'h0010, 15'h0080,
        15'h0100, 15'h0400, 15'h0800, 15'h412C};

    demod_serial_config_bank i_demod_serial_config_bank (
        .clk_i(clk_i), .rst_i(rst_i), .ser_clk_i(ser_clk),
        .ser_data_i(ser_data), .ser_strobe_i(ser_strobe), .osc_i(osc_i),
        .cal_done_i(cal_done_i), .cal_result_i(cal_result_i),
        .readback_o(readback_o), .setup_o(setup_o), .cal_ctrl_o(cal_ctrl_o),
        .load_o(load_o), .bias_o(bias_o), .cal_div_ratio_o(cal_div_ratio_o)
    );
    host_model host (
        .clk_i(clk_i), .readback_i(readback_o), .ser_clk_o(ser_clk),
        .ser_data_o(ser_data), .ser_strobe_o(ser_strobe)
    );

    // 50 MHz clock
    always #10 clk_i = ~clk_i;

    // cut a hang short
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 40000) begin
            n_fail++;
            close_out();
        end
    end

    task automatic chk(input string what, input logic [31:0] seen,
        input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // all stored registers against the shadow copy
    task automatic cmp_all();
        chk("setup", setup_o, sh[1]);
        chk("cal", cal_ctrl_o, sh[2]);
        chk("load", load_o, sh[3]);
        chk("bias", bias_o, sh[5]);
    endtask

    task automatic rd(input logic [2:0] n, input logic [31:0] exp);
        logic [31:0] v;
        host.read(n, v);
        chk("readback", v, exp);
    endtask

    task automatic close_out();
        $display("checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        clk_i = 1'b0;
        rst_i = 1'b1;
        osc_i = 1'b0;
        cal_done_i = 1'b0;
        cal_result_i = 16'h0000;
        repeat (3) @(negedge clk_i);
        rst_i = 1'b0;
        repeat (4) @(negedge clk_i);
        cmp_all();
        chk("ratio", {17'h0, cal_div_ratio_o}, 32'h1);
        rd(3'h0, {16'h8080, 9'h0, `VERSION_ID, 5'h08});
        // writes, clamped gain, forced zeros and refused words
        for (int k = 0; k < 8; k++) begin
            host.send(tw[k]);
            if (treg[k] != 3'h0) sh[treg[k]] = texp[k];
            cmp_all();
        end
        for (int k = 1; k < 6; k++) begin
            if (k != 4) rd(k[2:0], sh[k]);
        end
        // calibration start, completion and calibrated codes
        host.send(32'hAC56B0EA);
        chk("start", cal_ctrl_o, 32'hAC56B0EA);
        cal_result_i = 16'h3CC5;
        cal_done_i = 1'b1;
        @(negedge clk_i);
        cal_done_i = 1'b0;
        @(negedge clk_i);
        chk("done", cal_ctrl_o, 32'hAC56B0CA);
        rd(3'h0, {16'h3CC5, 9'h0, `VERSION_ID, 5'h08});
        // every divider code
        for (int k = 0; k < 8; k++) begin
            host.send({3'h5, 1'b0, k[2:0], 25'h056B0CA});
            chk("ratio", {17'h0, cal_div_ratio_o}, {17'h0, rt[k]});
        end
        // oscillator routed to the return output
        host.send(32'hBBFF8129);
        for (int k = 0; k < 4; k++) begin
            osc_i = k[0];
            repeat (12) @(negedge clk_i);
            chk("osc", {31'h0, readback_o}, {31'h0, k[0]});
        end
        close_out();
    end
endmodule
`default_nettype wire
